/* File: cbsb_pkg.sv */
// package: constants and carrier types for the bus agent side-band block
// Overview of operation
// - all flops launch and capture on bus clock
// - hold data busy while driving data words
// - drive ecc bits with data, strap-enabled
// - data strobe marks each valid data clock
// - open-drain fp error when unmasked error
// - flush writes back modified, then invalidates
// - flush acknowledge transaction after flush done
// - sample flush input at reset release
// - latch ratio select only in deep sleep
// - snoop stall drives hit and snoop_hit_modified together
// - internal error held until handled or init
// - ignore-error continues fp unless ne set
// - soft init resets integer state, restarts
// - keep snooping while soft init asserted
// - soft init at reset release runs self test
// - maskable irq when flag set, one ack
// - local irq pins act as irq, nmi
// - lock held first through last transaction
// - nmi uses internal vector, no acknowledge
// - nmi rising edge, one pending during handler
package cbsb_pkg;
  localparam int          CBSB_DATA_W     = 64;
  localparam int          CBSB_ECC_W      = 8;
  localparam logic [7:0]  CBSB_NMI_VECTOR = 8'h02;
  localparam int          CBSB_LINES      = 8;

  typedef struct packed {
    logic [CBSB_DATA_W-1:0] data;
    logic [CBSB_ECC_W-1:0]  ecc;
  } cbsb_beat_t;

  typedef enum logic [3:0] {
    CBSB_TX_NONE  = 4'h0,
    CBSB_TX_IRQ_ACKNOWLEDGE_CYCLE  = 4'h1,
    CBSB_TX_FLACK = 4'h2,
    CBSB_TX_SHUT  = 4'h3,
    CBSB_TX_WBACK = 4'h4
  } cbsb_txn_t;

  typedef enum logic [3:0] {
    CBSB_FL_IDLE = 4'b0001,
    CBSB_FL_WB   = 4'b0010,
    CBSB_FL_INV  = 4'b0100,
    CBSB_FL_ACK  = 4'b1000
  } cbsb_flush_st_t;
endpackage

/* File: cbsb_agent.sv */
// module: side-band and data-phase logic of the bus agent
`timescale 1ns/1ps
module cbsb_agent
  import cbsb_pkg::*;
#(
  parameter int LINES = cbsb_pkg::CBSB_LINES
) (
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  // data source (user side)
  input  wire cbsb_pkg::cbsb_beat_t   beat_in,
  input  wire logic                   beat_valid,
  output logic                        beat_ready,
  input  wire logic                   beat_last,
  // bus data phase
  output cbsb_pkg::cbsb_beat_t        bus_beat,
  output logic                        data_valid_strobe,
  output logic                        data_bus_busy,
  input  wire logic                   bus_stall,
  input  wire logic                   defer_response,
  // snoop
  input  wire logic                   snoop_req,
  input  wire logic                   snoop_stall_req,
  output logic                        snoop_hit,
  output logic                        snoop_hit_modified,
  // lock
  input  wire logic                   atomic_start,
  input  wire logic                   atomic_end,
  output logic                        atomic_lock,
  // special transactions
  output cbsb_pkg::cbsb_txn_t         bus_txn,
  output logic                        bus_txn_valid,
  // side-band pins
  input  wire logic                   cache_flush_in,
  input  wire logic                   soft_init_in,
  input  wire logic                   maskable_irq_in,
  input  wire logic                   nonmaskable_irq_in,
  input  wire logic [1:0]             local_irq_in,
  input  wire logic                   local_irq_ctrl_en,
  input  wire logic                   ratio_select_in,
  input  wire logic                   deep_sleep,
  input  wire logic                   clock_restart,
  input  wire logic                   bus_init,
  input  wire logic                   ignore_fp_error_in,
  input  wire logic                   numeric_error_enable_bit,
  input  wire logic                   fp_error_event,
  input  wire logic                   fp_error_masked,
  input  wire logic                   fp_instr,
  input  wire logic                   internal_error_event,
  input  wire logic                   error_handled,
  input  wire logic                   interrupt_flag_bit,
  input  wire logic                   instr_done,
  input  wire logic                   interrupt_return_instr,
  output logic                        fp_error_out,
  output logic                        fp_error_oe,
  output logic                        internal_error_out,
  output logic                        internal_error_oe,
  output logic                        fp_freeze,
  output logic                        ratio_sel_reg,
  output logic                        flush_strap,
  output logic                        ecc_enable,
  output logic                        self_test_run,
  output logic                        int_regs_reset,
  output logic [7:0]                  irq_vector,
  output logic                        irq_taken
);
  import cbsb_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers for pin inputs
  logic [6:0] s1_reg;
  logic [6:0] s2_reg;
  logic [6:0] pins;
  assign pins = {cache_flush_in, soft_init_in, maskable_irq_in,
                 nonmaskable_irq_in, local_irq_in, ratio_select_in};
  always_ff @(posedge clock) begin
    s1_reg <= pins;
    s2_reg <= s1_reg;
  end
  logic flush_s, init_s, irq_s, nmi_pin_s, ratio_s;
  logic [1:0] lint_s;
  assign {flush_s, init_s, irq_s, nmi_pin_s, lint_s, ratio_s} = s2_reg;
  logic irq_src, nmi_src;
  assign irq_src = local_irq_ctrl_en ? irq_s : lint_s[0];
  assign nmi_src = local_irq_ctrl_en ? nmi_pin_s : lint_s[1];

  ////////////////////////////////////////////////////////////////////////////
  // power-on straps caught on the first clock after reset release
  logic rst_d_reg;
  always_ff @(posedge clock) begin
    rst_d_reg <= rst_n;
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flush_strap   <= 1'b0;
      ecc_enable    <= 1'b0;
      self_test_run <= 1'b0;
    end else if (!rst_d_reg) begin
      flush_strap   <= flush_s;
      ecc_enable    <= flush_s;
      self_test_run <= init_s;
    end else begin
      self_test_run <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // two-entry skid buffer feeding the data phase
  cbsb_beat_t buf_reg [2];
  logic [1:0] last_reg;
  logic [1:0] cnt_reg;
  logic       rd_reg, wr_reg;
  logic       push, pop;
  assign push = beat_valid && beat_ready;
  assign pop  = (cnt_reg != 2'h0) && !bus_stall;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_reg <= 2'h0;
      rd_reg  <= 1'b0;
      wr_reg  <= 1'b0;
    end else begin
      if (push) begin
        buf_reg[wr_reg]  <= beat_in;
        last_reg[wr_reg] <= beat_last;
        wr_reg           <= ~wr_reg;
      end
      if (pop) rd_reg <= ~rd_reg;
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) beat_ready <= 1'b1;
    else beat_ready <= (cnt_reg + {1'b0, push} - {1'b0, pop}) < 2'h2;
  end

  // strobe only on beats carrying data; busy spans the whole burst
  logic burst_reg;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bus_beat          <= '0;
      data_valid_strobe <= 1'b0;
      data_bus_busy     <= 1'b0;
      burst_reg         <= 1'b0;
    end else begin
      data_valid_strobe <= pop;
      if (pop) bus_beat <= buf_reg[rd_reg];
      if (pop && last_reg[rd_reg]) burst_reg <= 1'b0;
      else if (pop || cnt_reg != 2'h0) burst_reg <= 1'b1;
      data_bus_busy <= pop || (burst_reg && !(pop && last_reg[rd_reg]));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // snoop: answer even during soft init; stall asserts both lines
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      snoop_hit          <= 1'b0;
      snoop_hit_modified <= 1'b0;
    end else begin
      snoop_hit          <= snoop_req && snoop_stall_req;
      snoop_hit_modified <= snoop_req && snoop_stall_req;
    end
  end

  // lock from first to last transaction; defer does not drop it
  always_ff @(posedge clock) begin
    if (!rst_n) atomic_lock <= 1'b0;
    else if (atomic_start) atomic_lock <= 1'b1;
    else if (atomic_end) atomic_lock <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // flush engine, one line per clock
  cbsb_flush_st_t fl_reg;
  logic [$clog2(LINES)-1:0] line_reg;
  logic flush_d_reg;
  logic fl_req;
  assign fl_req = flush_s && !flush_d_reg;
  always_ff @(posedge clock) begin
    if (!rst_n) flush_d_reg <= 1'b0;
    else flush_d_reg <= flush_s;
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fl_reg   <= CBSB_FL_IDLE;
      line_reg <= '0;
    end else begin
      unique case (fl_reg)
        CBSB_FL_IDLE: if (fl_req) fl_reg <= CBSB_FL_WB;
        CBSB_FL_WB: begin
          line_reg <= line_reg + 1'b1;
          if (line_reg == ($clog2(LINES))'(LINES - 1)) fl_reg <= CBSB_FL_INV;
        end
        CBSB_FL_INV: fl_reg <= CBSB_FL_ACK;
        CBSB_FL_ACK: fl_reg <= CBSB_FL_IDLE;
        default: fl_reg <= CBSB_FL_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts
  logic nmi_d_reg, nmi_pend_reg, in_nmi_reg, internal_error_out_d_reg;
  logic nmi_rise, take_nmi, take_irq;
  assign nmi_rise = nmi_src && !nmi_d_reg;
  assign take_nmi = instr_done && !in_nmi_reg && (nmi_rise || nmi_pend_reg);
  // a colliding flush ack or shutdown wins; the source holds its request
  assign take_irq = instr_done && !take_nmi && interrupt_flag_bit
                    && irq_src && !init_s && fl_reg != CBSB_FL_ACK
                    && !(internal_error_out && !internal_error_out_d_reg);
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      nmi_d_reg    <= 1'b0;
      nmi_pend_reg <= 1'b0;
      in_nmi_reg   <= 1'b0;
      irq_vector   <= '0;
      irq_taken    <= 1'b0;
    end else begin
      nmi_d_reg <= nmi_src;
      irq_taken <= take_nmi || take_irq;
      if (take_nmi) begin
        in_nmi_reg   <= 1'b1;
        // a fresh edge arriving while a pending one is taken stays pending
        nmi_pend_reg <= nmi_pend_reg && nmi_rise;
        irq_vector   <= CBSB_NMI_VECTOR;
      end else begin
        if (nmi_rise) nmi_pend_reg <= 1'b1;
        if (interrupt_return_instr) in_nmi_reg <= 1'b0;
      end
    end
  end

  // one special transaction per clock; priority flush ack, shutdown, irq_acknowledge_cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bus_txn       <= CBSB_TX_NONE;
      bus_txn_valid <= 1'b0;
      internal_error_out_d_reg    <= 1'b0;
    end else begin
      // a shutdown blocked by a flush ack goes out on the next clock
      if (fl_reg != CBSB_FL_ACK) internal_error_out_d_reg <= internal_error_out;
      bus_txn_valid <= 1'b1;
      if (fl_reg == CBSB_FL_ACK) bus_txn <= CBSB_TX_FLACK;
      else if (internal_error_out && !internal_error_out_d_reg)
        bus_txn <= CBSB_TX_SHUT;
      else if (take_irq) bus_txn <= CBSB_TX_IRQ_ACKNOWLEDGE_CYCLE;
      else if (fl_reg == CBSB_FL_WB) bus_txn <= CBSB_TX_WBACK;
      else begin
        bus_txn       <= CBSB_TX_NONE;
        bus_txn_valid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // errors, fp control, soft init, ratio
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      internal_error_out <= 1'b0;
      internal_error_oe  <= 1'b0;
    end else if (internal_error_event) begin
      internal_error_out <= 1'b1;
      internal_error_oe  <= 1'b1;
    end else if (error_handled || bus_init || init_s) begin
      internal_error_out <= 1'b0;
      internal_error_oe  <= 1'b0;
    end
  end
  logic fp_pend_reg;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fp_pend_reg  <= 1'b0;
      fp_error_out <= 1'b0;
      fp_error_oe  <= 1'b0;
      fp_freeze    <= 1'b0;
    end else begin
      if (fp_error_event && !fp_error_masked) fp_pend_reg <= 1'b1;
      else if (error_handled) fp_pend_reg <= 1'b0;
      fp_error_out <= fp_pend_reg;
      fp_error_oe  <= fp_pend_reg;
      fp_freeze    <= fp_pend_reg && fp_instr && !numeric_error_enable_bit
                      && !ignore_fp_error_in;
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      int_regs_reset <= 1'b0;
      ratio_sel_reg  <= 1'b0;
    end else begin
      int_regs_reset <= init_s;
      if (deep_sleep && clock_restart) ratio_sel_reg <= ratio_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_STROBE_BUSY: assert property (@(posedge clock) disable iff (!rst_n)
    data_valid_strobe |-> data_bus_busy)
    else $error("strobe without busy");
  AST_STROBE_POP: assert property (@(posedge clock) disable iff (!rst_n)
    pop |=> data_valid_strobe)
    else $error("beat not strobed");
  AST_STALL_PAIR: assert property (@(posedge clock) disable iff (!rst_n)
    snoop_hit == snoop_hit_modified)
    else $error("stall lines differ");
  AST_SNOOP_INIT: assert property (@(posedge clock) disable iff (!rst_n)
    (snoop_req && snoop_stall_req && init_s) |=> snoop_hit)
    else $error("snoop dropped in init");
  AST_FLUSH_ACK: assert property (@(posedge clock) disable iff (!rst_n)
    fl_reg == CBSB_FL_INV |=> ##1 bus_txn == CBSB_TX_FLACK)
    else $error("no flush ack");
  AST_INTERNAL_ERROR_OUT_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
    internal_error_out && !error_handled && !bus_init && !init_s
    |=> internal_error_out)
    else $error("internal_error_out dropped");
  AST_NMI_VEC: assert property (@(posedge clock) disable iff (!rst_n)
    take_nmi |=> irq_vector == CBSB_NMI_VECTOR && bus_txn != CBSB_TX_IRQ_ACKNOWLEDGE_CYCLE)
    else $error("nmi vector wrong");
  AST_IRQ_ACKNOWLEDGE_CYCLE_ONE: assert property (@(posedge clock) disable iff (!rst_n)
    take_irq |=> bus_txn == CBSB_TX_IRQ_ACKNOWLEDGE_CYCLE && bus_txn_valid)
    else $error("irq_acknowledge_cycle missing");
  AST_RATIO_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
    !deep_sleep |=> $stable(ratio_sel_reg))
    else $error("ratio changed out of sleep");
  AST_FREEZE_NE: assert property (@(posedge clock) disable iff (!rst_n)
    numeric_error_enable_bit |=> !fp_freeze)
    else $error("freeze with ne set");
  COV_FLUSH: cover property (@(posedge clock) fl_reg == CBSB_FL_ACK);
  COV_NMI_PEND: cover property (@(posedge clock) in_nmi_reg && nmi_rise);
  COV_FULL: cover property (@(posedge clock) cnt_reg == 2'h2 && bus_stall);
  COV_DEFER: cover property (@(posedge clock) defer_response && data_bus_busy);
endmodule

/* File: cbsb_far_agent.sv */
// far bus agent model: receiver stall, defer and beat capture
`timescale 1ns/1ps
module cbsb_far_agent
  import cbsb_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic                 stall_cmd,
  input  wire cbsb_pkg::cbsb_beat_t bus_beat,
  input  wire logic                 data_valid_strobe,
  input  wire logic                 atomic_lock,
  input  wire logic                 priority_bus_request,
  output logic                      bus_stall,
  output logic                      defer_response,
  output cbsb_pkg::cbsb_beat_t      last_beat,
  output logic [7:0]                beat_cnt,
  output logic                      prio_owner
);
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      beat_cnt  <= 8'h00;
      last_beat <= '0;
    end else if (data_valid_strobe) begin
      beat_cnt  <= beat_cnt + 8'h01;
      last_beat <= bus_beat;
    end
  end
  // defer every fourth beat; the agent only observes it
  assign defer_response = data_valid_strobe && beat_cnt[1:0] == 2'h3;
  assign bus_stall      = stall_cmd;
  // priority agent takes the bus only once it sees the lock released
  always_ff @(posedge clock) begin
    if (!rst_n) prio_owner <= 1'b0;
    else prio_owner <= priority_bus_request && !atomic_lock;
  end
endmodule

/* File: cbsb_agent_tb.sv */
// self-checking bench for the bus agent side-band block
`timescale 1ns/1ps
module cbsb_agent_tb;
  import cbsb_pkg::*;
  logic clock, rst_n, beat_valid, beat_last, bus_stall, defer_response;
  logic snoop_req, snoop_stall_req, atomic_start, atomic_end, stall_cmd;
  logic cache_flush_in, soft_init_in, maskable_irq_in, nonmaskable_irq_in;
  logic local_irq_ctrl_en, ratio_select_in, deep_sleep, clock_restart;
  logic bus_init, ignore_fp_error_in, numeric_error_enable_bit;
  logic fp_error_event, fp_error_masked, fp_instr, internal_error_event;
  logic error_handled, interrupt_flag_bit, instr_done;
  logic interrupt_return_instr, priority_bus_request, prio_owner;
  logic [1:0]  local_irq_in;
  cbsb_beat_t  beat_in, bus_beat, last_beat;
  logic beat_ready, data_valid_strobe, data_bus_busy, snoop_hit;
  logic snoop_hit_modified, atomic_lock, bus_txn_valid, fp_error_out;
  logic fp_error_oe, internal_error_out, internal_error_oe, fp_freeze;
  logic ratio_sel_reg, flush_strap, ecc_enable, self_test_run;
  logic int_regs_reset, irq_taken;
  logic [7:0]  irq_vector, beat_cnt;
  cbsb_txn_t   bus_txn;
  cbsb_beat_t  rows [4];
  int bad_count, cmp_count, n_irq_acknowledge_cycle, n_flack, n_shut, n_wback, n_irq, n_built_in_self_test;

  cbsb_agent     cbsb_agent_i (.*);
  cbsb_far_agent cbsb_far_agent_i (.*);

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    if (bus_txn_valid && bus_txn === CBSB_TX_IRQ_ACKNOWLEDGE_CYCLE) n_irq_acknowledge_cycle++;
    if (bus_txn_valid && bus_txn === CBSB_TX_FLACK) n_flack++;
    if (bus_txn_valid && bus_txn === CBSB_TX_SHUT) n_shut++;
    if (bus_txn_valid && bus_txn === CBSB_TX_WBACK) n_wback++;
    if (irq_taken === 1'b1) n_irq++;
    if (self_test_run === 1'b1) n_built_in_self_test++;
    if (data_valid_strobe === 1'b1) chk(data_bus_busy, 1'b1);
  end

  task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // hold the beat until an edge samples ready high
  task automatic send(input cbsb_beat_t b, input logic l);
    int k;
    k = 0;
    beat_in = b;
    beat_last = l;
    beat_valid = 1'b1;
    do begin
      @(posedge clock);
      k++;
    end while (beat_ready !== 1'b1 && k < 50);
    #1 beat_valid = 1'b0;
    // let an edge pass so a following send never re-raises valid at once
    cyc(1);
  endtask

  task automatic wait_beats(input int n);
    int k;
    for (k = 0; k < 60 && beat_cnt !== 8'(n); k++) cyc(1);
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask

  initial begin
    #100000;
    bad_count++;
    conclude();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, beat_valid, beat_last, snoop_req, snoop_stall_req, atomic_start,
     atomic_end, stall_cmd, cache_flush_in, soft_init_in, maskable_irq_in,
     nonmaskable_irq_in, ratio_select_in, deep_sleep, clock_restart,
     bus_init, ignore_fp_error_in, numeric_error_enable_bit, fp_error_event,
     fp_error_masked, fp_instr, internal_error_event, error_handled,
     interrupt_flag_bit, instr_done, interrupt_return_instr, local_irq_in,
     beat_in, priority_bus_request} = '0;
    local_irq_ctrl_en = 1'b1;
    rows[0] = {64'h0000_0000_0000_0000, 8'h00};
    rows[1] = {64'hFFFF_FFFF_FFFF_FFFF, 8'hFF};
    rows[2] = {64'hA5A5_5A5A_0F0F_F0F0, 8'h3C};
    rows[3] = {64'h0123_4567_89AB_CDEF, 8'hC3};
    cyc(8);
    chk({beat_ready, data_bus_busy, atomic_lock, flush_strap}, 4'h8);
    rst_n = 1'b1;
    for (int i = 0; i < 4; i++) begin
      send(rows[i], i == 3);
      wait_beats(i + 1);
      chk(last_beat, rows[i]);
    end
    cyc(3);
    chk(data_bus_busy, 1'b0);
    // receiver stall: two words held, third refused
    stall_cmd = 1'b1;
    send(rows[1], 1'b0);
    send(rows[2], 1'b1);
    cyc(3);
    chk({beat_ready, beat_cnt}, 9'h004);
    stall_cmd = 1'b0;
    wait_beats(6);
    chk(last_beat, rows[2]);
    // snoop stall requested while soft init is active
    {snoop_req, snoop_stall_req, soft_init_in} = 3'h7;
    cyc(4);
    chk({snoop_hit, snoop_hit_modified, int_regs_reset}, 3'h7);
    {snoop_req, snoop_stall_req, soft_init_in} = 3'h0;
    pulse(atomic_start);
    priority_bus_request = 1'b1;
    cyc(6);
    chk({atomic_lock, prio_owner}, 2'h2);
    pulse(atomic_end);
    cyc(2);
    chk({atomic_lock, prio_owner}, 2'h1);
    priority_bus_request = 1'b0;
    cache_flush_in = 1'b1;
    cyc(4);
    cache_flush_in = 1'b0;
    cyc(30);
    chk({n_flack, n_wback}, {32'd1, 32'(CBSB_LINES)});
    pulse(internal_error_event);
    cyc(4);
    chk({internal_error_out, internal_error_oe, n_shut}, {2'h3, 32'd1});
    pulse(error_handled);
    cyc(2);
    chk(internal_error_out, 1'b0);
    pulse(internal_error_event);
    cyc(3);
    pulse(bus_init);
    cyc(2);
    chk(internal_error_out, 1'b0);
    pulse(fp_error_event);
    cyc(3);
    chk({fp_error_out, fp_error_oe}, 2'h3);
    fp_instr = 1'b1;
    cyc(2);
    chk(fp_freeze, 1'b1);
    ignore_fp_error_in = 1'b1;
    cyc(2);
    chk(fp_freeze, 1'b0);
    ignore_fp_error_in = 1'b0;
    numeric_error_enable_bit = 1'b1;
    cyc(2);
    chk(fp_freeze, 1'b0);
    {fp_instr, numeric_error_enable_bit} = 2'h0;
    // irq held until its acknowledge appears
    interrupt_flag_bit = 1'b1;
    maskable_irq_in = 1'b1;
    cyc(4);
    pulse(instr_done);
    for (int k = 0; k < 40 && n_irq_acknowledge_cycle == 0; k++) cyc(1);
    maskable_irq_in = 1'b0;
    cyc(10);
    chk(n_irq_acknowledge_cycle, 1);
    // instructions keep retiring so an nmi is taken as soon as it is seen
    instr_done = 1'b1;
    nonmaskable_irq_in = 1'b1;
    cyc(8);
    chk({n_irq, irq_vector, n_irq_acknowledge_cycle}, {32'd2, CBSB_NMI_VECTOR, 32'd1});
    nonmaskable_irq_in = 1'b0;
    repeat (2) begin
      cyc(4);
      pulse(nonmaskable_irq_in);
    end
    cyc(8);
    chk(n_irq, 2);
    pulse(interrupt_return_instr);
    cyc(8);
    chk(n_irq, 3);
    pulse(interrupt_return_instr);
    local_irq_ctrl_en = 1'b0;
    local_irq_in = 2'h2;
    cyc(8);
    chk({n_irq, irq_vector}, {32'd4, CBSB_NMI_VECTOR});
    instr_done = 1'b0;
    ratio_select_in = 1'b1;
    cyc(4);
    pulse(clock_restart);
    cyc(2);
    chk(ratio_sel_reg, 1'b0);
    deep_sleep = 1'b1;
    pulse(clock_restart);
    cyc(2);
    chk(ratio_sel_reg, 1'b1);
    // second reset with both straps high
    rst_n = 1'b0;
    cache_flush_in = 1'b1;
    soft_init_in = 1'b1;
    n_built_in_self_test = 0;
    cyc(8);
    rst_n = 1'b1;
    cyc(6);
    chk({flush_strap, n_built_in_self_test, int_regs_reset}, {1'b1, 32'd1, 1'b1});
    chk(ecc_enable, 1'b1);
    conclude();
  end
endmodule
